/* File: rtl/pct_pkg.sv */
// pct_pkg: types and constants for the pwm/capture timer.
// assumes one kernel clock; configuration arrives as plain ports.
package pct_pkg;
  localparam int PCT_CNT_W = 16;
  localparam int PCT_PSC_W = 16;
  localparam int PCT_NCH = 4;
  localparam int PCT_DT_W = 8;
  localparam logic [15:0] PCT_ZERO = 16'h0000;
  localparam logic [15:0] PCT_ONE = 16'h0001;
  localparam logic [7:0] PCT_DT_ONE = 8'h01;
  localparam int PCT_CLK_HZ = 40000000;
  localparam int PCT_PLL_HZ = 144000000;

  typedef enum logic [1:0] {
    PCT_DIR_UP,
    PCT_DIR_DOWN,
    PCT_DIR_UPDOWN,
    PCT_DIR_ENC
  } pct_cmode_t;

  typedef enum logic [1:0] {
    PCT_CH_CAPTURE,
    PCT_CH_COMPARE,
    PCT_CH_PWM,
    PCT_CH_ONEPULSE
  } pct_chmode_t;

  typedef struct packed {
    logic enable;
    pct_cmode_t cmode;
    logic one_pulse;
    logic freeze_en;
    logic [PCT_PSC_W-1:0] psc;
    logic [PCT_CNT_W-1:0] arr;
    logic [PCT_DT_W-1:0] dead;
  } pct_cfg_t;

  typedef struct packed {
    pct_chmode_t mode;
    logic [PCT_CNT_W-1:0] cmp;
  } pct_chcfg_t;

  typedef struct packed {
    logic update;
    logic [PCT_NCH-1:0] chan;
  } pct_evt_t;
endpackage : pct_pkg

/* File: rtl/pct_timer.sv */
// pct_timer: 16-bit auto-reload timer, prescaler, four channels, dead time.
// assumes all inputs synchronous to clk; config stable while running.
// Contract
// - 16-bit counter behind 16-bit prescaler; up, down or up/down counting.
// - four channels, each capture, compare, pwm or one-pulse.
// - edge and centre aligned pwm, duty from 0 to 100 percent.
// - complementary outputs with programmable dead time between transitions.
// - each of the four channels drives a complementary pin pair, eight pins in all.
// - debug halt with freeze stops counter and forces outputs inactive.
// - own dma requests on update and channel events.
// - quadrature encoder inputs count up or down by phase.
// - trigger in/out links to other timers for sync or chaining.
// - kernel clock may come from pll; counting logic is fully synchronous.
`timescale 1ns/1ps
`default_nettype none
module pct_timer
  import pct_pkg::*;
#(
  parameter int CNT_W = PCT_CNT_W,
  parameter int NCH = PCT_NCH
) (
  input wire logic clk,
  input wire logic rstn,
  input wire pct_cfg_t cfg,
  input wire pct_chcfg_t [NCH-1:0] chcfg,
  input wire logic start,
  input wire logic dbg_halt,
  input wire logic trig_in,
  input wire logic enc_a,
  input wire logic enc_b,
  input wire logic [NCH-1:0] cap_in,
  output logic [NCH-1:0] out_p,
  output logic [NCH-1:0] out_n,
  output logic [CNT_W-1:0] count,
  output logic [CNT_W-1:0] capture [NCH],
  output pct_evt_t dma_req,
  output logic trig_out,
  output logic running
);
  // same edge-detect used for capture inputs and encoder phase a
  function automatic logic rise(input logic prev, input logic cur);
    return cur & ~prev;
  endfunction : rise

  logic [PCT_PSC_W-1:0] psc_cnt, next_psc_cnt;
  logic [CNT_W-1:0] next_count;
  logic dir_down, next_dir_down;
  logic next_running;
  logic enc_a_q;
  logic [NCH-1:0] cap_q;
  logic [NCH-1:0] ref_q, next_ref;
  logic [NCH-1:0] ref_d;
  logic [PCT_DT_W-1:0] dt_cnt [NCH];
  logic [PCT_DT_W-1:0] next_dt_cnt [NCH];
  logic [CNT_W-1:0] next_capture [NCH];
  logic [NCH-1:0] next_out_p, next_out_n;
  pct_evt_t next_dma;
  logic next_trig;
  logic frozen, tick, upd, enc_step, enc_up;

  // freeze only while halted and allowed; stops prescaler too
  assign frozen = dbg_halt & cfg.freeze_en;
  assign tick = running & ~frozen & (psc_cnt == cfg.psc);
  // x1 encoding on rising a edge, direction from b phase
  assign enc_step = rise(enc_a_q, enc_a);
  assign enc_up = ~enc_b;

  always_comb begin
    next_psc_cnt = psc_cnt;
    next_count = count;
    next_dir_down = dir_down;
    next_running = running;
    upd = 1'b0;
    if (running && !frozen && cfg.cmode != PCT_DIR_ENC) begin
      next_psc_cnt = (psc_cnt == cfg.psc) ? PCT_ZERO : psc_cnt + PCT_ONE;
    end
    if (running && !frozen && cfg.cmode == PCT_DIR_ENC && enc_step) begin
      if (enc_up) begin
        upd = (count == cfg.arr);
        next_count = upd ? PCT_ZERO : count + PCT_ONE;
      end else begin
        upd = (count == PCT_ZERO);
        next_count = upd ? cfg.arr : count - PCT_ONE;
      end
    end else if (tick) begin
      case (cfg.cmode)
        PCT_DIR_UP: begin
          upd = (count == cfg.arr);
          next_count = upd ? PCT_ZERO : count + PCT_ONE;
        end
        PCT_DIR_DOWN: begin
          upd = (count == PCT_ZERO);
          next_count = upd ? cfg.arr : count - PCT_ONE;
        end
        PCT_DIR_UPDOWN: begin
          // centre-aligned: turn at arr and at zero, update at both ends
          if (!dir_down) begin
            upd = (count == cfg.arr);
            next_dir_down = upd;
            next_count = upd ? count - PCT_ONE : count + PCT_ONE;
          end else begin
            upd = (count == PCT_ZERO);
            next_dir_down = ~upd;
            next_count = upd ? count + PCT_ONE : count - PCT_ONE;
          end
        end
        default: next_count = count;
      endcase
    end
    if (upd && cfg.one_pulse) begin
      next_running = 1'b0;
    end
    // start from software or from a linked timer's trigger
    if (!running && cfg.enable && (start || trig_in)) begin
      next_running = 1'b1;
      // restart from a known point; a stale count may sit above a new reload value
      next_psc_cnt = PCT_ZERO;
      next_count = (cfg.cmode == PCT_DIR_DOWN) ? cfg.arr : PCT_ZERO;
      next_dir_down = 1'b0;
    end
    if (!cfg.enable) begin
      next_running = 1'b0;
    end
  end

  always_comb begin
    next_dma = '0;
    next_dma.update = upd;
    next_trig = upd;
    for (int i = 0; i < NCH; i++) begin
      next_capture[i] = capture[i];
      next_ref[i] = ref_q[i];
      case (chcfg[i].mode)
        PCT_CH_CAPTURE: begin
          if (rise(cap_q[i], cap_in[i])) begin
            next_capture[i] = count;
            next_dma.chan[i] = 1'b1;
          end
          next_ref[i] = 1'b0;
        end
        PCT_CH_COMPARE: begin
          // toggle on match; matches only count on a prescaler tick, which in encoder mode is not an encoder step
          if (tick && count == chcfg[i].cmp) begin
            next_ref[i] = ~ref_q[i];
            next_dma.chan[i] = 1'b1;
          end
        end
        PCT_CH_PWM, PCT_CH_ONEPULSE: begin
          // cmp=0 gives 0%, cmp>arr gives 100%
          next_ref[i] = (count < chcfg[i].cmp);
          if (chcfg[i].mode == PCT_CH_ONEPULSE && !running) begin
            next_ref[i] = 1'b0;
          end
          if (tick && count == chcfg[i].cmp) begin
            next_dma.chan[i] = 1'b1;
          end
        end
        default: next_ref[i] = 1'b0;
      endcase
    end
  end

  // dead time: the rising side waits dead cycles after ref changes
  always_comb begin
    for (int i = 0; i < NCH; i++) begin
      ref_d[i] = ref_q[i];
      next_dt_cnt[i] = dt_cnt[i];
      if (next_ref[i] != ref_q[i]) begin
        next_dt_cnt[i] = cfg.dead;
      end else if (dt_cnt[i] != '0) begin
        next_dt_cnt[i] = dt_cnt[i] - PCT_DT_ONE;
      end
      // every channel 0..3 drives its own complementary pair, eight pins
      next_out_p[i] = ref_q[i] & (dt_cnt[i] == '0);
      next_out_n[i] = ~ref_d[i] & (dt_cnt[i] == '0);
      if (chcfg[i].mode == PCT_CH_CAPTURE || frozen) begin
        next_out_p[i] = 1'b0;
        next_out_n[i] = 1'b0;
      end
    end
  end

  // one clock domain; no path depends on clock ratio, so pll rates are fine
  always_ff @(posedge clk) begin
    if (!rstn) begin
      psc_cnt <= PCT_ZERO;
      count <= PCT_ZERO;
      dir_down <= 1'b0;
      running <= 1'b0;
    end else begin
      psc_cnt <= next_psc_cnt;
      count <= next_count;
      dir_down <= next_dir_down;
      running <= next_running;
    end
  end

  // previous samples for the edge detectors
  always_ff @(posedge clk) begin
    if (!rstn) begin
      enc_a_q <= 1'b0;
      cap_q <= '0;
    end else begin
      enc_a_q <= enc_a;
      cap_q <= cap_in;
    end
  end

  // channel references, captures and event pulses
  always_ff @(posedge clk) begin
    if (!rstn) begin
      ref_q <= '0;
      dma_req <= '0;
      trig_out <= 1'b0;
      for (int i = 0; i < NCH; i++) begin
        capture[i] <= PCT_ZERO;
      end
    end else begin
      ref_q <= next_ref;
      dma_req <= next_dma;
      trig_out <= next_trig;
      for (int i = 0; i < NCH; i++) begin
        capture[i] <= next_capture[i];
      end
    end
  end

  // dead-time counters and output pins
  always_ff @(posedge clk) begin
    if (!rstn) begin
      out_p <= '0;
      out_n <= '0;
      for (int i = 0; i < NCH; i++) begin
        dt_cnt[i] <= '0;
      end
    end else begin
      out_p <= next_out_p;
      out_n <= next_out_n;
      for (int i = 0; i < NCH; i++) begin
        dt_cnt[i] <= next_dt_cnt[i];
      end
    end
  end
endmodule : pct_timer
`default_nettype wire

/* File: tb/pct_properties.sv */
// pct_chk: port assertions for pct_timer.
// assumes a bind onto pct_timer; one clock domain.
`timescale 1ns/1ps
`default_nettype none
module pct_chk
  import pct_pkg::*;
#(parameter int CNT_W = 16, parameter int NCH = 4) (
  input wire logic clk,
  input wire logic rstn,
  input wire pct_cfg_t cfg,
  input wire logic start,
  input wire logic dbg_halt,
  input wire logic [NCH-1:0] out_p,
  input wire logic [NCH-1:0] out_n,
  input wire logic [CNT_W-1:0] count,
  input wire pct_evt_t dma_req,
  input wire logic trig_out,
  input wire logic running
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rstn);
  logic go;
  logic halt;
  // plain up count, no prescale: every cycle is a tick
  assign go = running && cfg.enable && !dbg_halt && cfg.psc == 16'h0 && cfg.cmode == PCT_DIR_UP;
  assign halt = dbg_halt && cfg.freeze_en;
  start_run_a: assert property (!running && cfg.enable && start && !dbg_halt |=> running)
    else $error("start ignored");
  count_step_a: assert property (go && count != cfg.arr |=> count == $past(count) + 1'b1)
    else $error("bad count step");
  reload_wrap_a: assert property (go && count == cfg.arr |=> count == 16'h0 && dma_req.update)
    else $error("no wrap at reload");
  trig_link_a: assert property (trig_out == dma_req.update)
    else $error("trigger out differs from update");
  pulse_stop_a: assert property (dma_req.update && $past(cfg.one_pulse) |-> !running)
    else $error("one pulse still running");
  freeze_out_a: assert property (halt |=> out_p == '0 && out_n == '0)
    else $error("outputs live while frozen");
  freeze_hold_a: assert property (halt [*2] |=> $stable(count))
    else $error("count moved while frozen");
  no_overlap_a: assert property ((out_p & out_n) == '0)
    else $error("both outputs high");
endmodule : pct_chk
bind pct_timer pct_chk #(.CNT_W(CNT_W), .NCH(NCH)) i_pct_chk (.clk(clk), .rstn(rstn),
  .cfg(cfg), .start(start), .dbg_halt(dbg_halt), .out_p(out_p), .out_n(out_n),
  .count(count), .dma_req(dma_req), .trig_out(trig_out), .running(running));
`default_nettype wire

/* File: tb/pct_partner.sv */
// pct_partner: switch pairs as load, pseudo-random capture sources.
// assumes clk shared with the timer.
`timescale 1ns/1ps
`default_nettype none
module pct_partner (
  input wire logic clk,
  input wire logic [3:0] out_p,
  input wire logic [3:0] out_n,
  output logic [3:0] cap_in = 4'h0,
  output logic shoot = 1'b0
);
  logic [15:0] lfsr = 16'hace1;
  always @(posedge clk) begin
    lfsr <= {lfsr[14:0], lfsr[15] ^ lfsr[13]};
    cap_in <= lfsr[3:0];
    // a leg with both switches on would short the supply
    shoot <= shoot | (|(out_p & out_n));
  end
endmodule : pct_partner
`default_nettype wire

/* File: tb/testbench.sv */
// testbench: random timer runs against a partner model.
// assumes the checker is bound in its own file.
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import pct_pkg::*;
  logic clk = 1'b0;
  logic rstn = 1'b0;
  pct_cfg_t cfg = '0;
  pct_chcfg_t [3:0] chcfg = '0;
  logic start = 1'b0, dbg_halt = 1'b0, trig_in = 1'b0, enc_a = 1'b0, enc_b = 1'b0;
  logic [3:0] cap_in, out_p, out_n;
  logic [15:0] count, base;
  logic [15:0] capture [4];
  pct_evt_t dma_req;
  logic trig_out, running, shoot;
  int seed = 14;
  int num_errors = 0;
  int check_count = 0;
  int cycles = 0;
  always #12.5 clk = ~clk;
  pct_timer i_pct_timer (.clk(clk), .rstn(rstn), .cfg(cfg), .chcfg(chcfg), .start(start),
    .dbg_halt(dbg_halt), .trig_in(trig_in), .enc_a(enc_a), .enc_b(enc_b), .cap_in(cap_in),
    .out_p(out_p), .out_n(out_n), .count(count), .capture(capture), .dma_req(dma_req),
    .trig_out(trig_out), .running(running));
  pct_partner i_pct_partner (.clk(clk), .out_p(out_p), .out_n(out_n), .cap_in(cap_in),
    .shoot(shoot));
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      num_errors++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic conclude();
    $display("errors %0d checks %0d", num_errors, check_count);
    if (num_errors == 0 && check_count > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : conclude
  // updown turns at both ends, so one fewer step between updates
  function automatic int period(input pct_cfg_t c);
    return (int'(c.arr) + (c.cmode == PCT_DIR_UPDOWN ? 0 : 1)) * (int'(c.psc) + 1);
  endfunction : period
  task automatic wait_upd(output int n);
    n = 0;
    do begin
      @(negedge clk);
      n++;
    end while (dma_req.update !== 1'b1 && n < 9000);
    if (n >= 9000) num_errors++;
  endtask : wait_upd
  task automatic kick(input logic link);
    @(posedge clk);
    if (link) trig_in <= 1'b1;
    else start <= 1'b1;
    @(posedge clk);
    trig_in <= 1'b0;
    start <= 1'b0;
  endtask : kick
  task automatic enc_steps(input logic dir, input int k);
    repeat (k) begin
      @(posedge clk);
      enc_b <= dir;
      enc_a <= 1'b1;
      repeat (3) @(posedge clk);
      enc_a <= 1'b0;
      repeat (2) @(posedge clk);
    end
  endtask : enc_steps
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 60000) begin
      num_errors++;
      conclude();
    end
  end
  initial begin
    int n;
    int k;
    pct_cfg_t c;
    repeat (6) @(posedge clk);
    rstn <= 1'b1;
    for (int r = 0; r < 9; r++) begin
      c = '{1'b1, pct_cmode_t'(r % 3), 1'b0, 1'b1, 16'(r % 3), 16'(4 + {$random(seed)} % 20),
        8'h02};
      cfg <= c;
      chcfg <= {pct_chcfg_t'{pct_chmode_t'(r % 4), 16'h3}, pct_chcfg_t'{PCT_CH_CAPTURE, 16'h0},
        pct_chcfg_t'{PCT_CH_PWM, 16'h0}, pct_chcfg_t'{PCT_CH_PWM, c.arr >> 1}};
      kick(r[0]);
      wait_upd(n);
      check(trig_out, 1'b1);
      wait_upd(n);
      check(n, period(c));
      @(posedge clk);
      dbg_halt <= 1'b1;
      repeat (3) @(negedge clk);
      base = count;
      repeat (3) @(negedge clk);
      check(count, base);
      check(out_p | out_n, 4'h0);
      @(posedge clk);
      dbg_halt <= 1'b0;
      cfg.one_pulse <= 1'b1;
      wait_upd(n);
      @(negedge clk);
      check(running, 1'b0);
    end
    cfg <= '{1'b1, PCT_DIR_ENC, 1'b0, 1'b0, 16'h0, 16'hffff, 8'h01};
    kick(1'b0);
    k = 2 + {$random(seed)} % 6;
    @(negedge clk);
    base = count;
    enc_steps(1'b0, k);
    @(negedge clk);
    check(count, base + 16'(k));
    enc_steps(1'b1, k);
    @(negedge clk);
    check(count, base);
    check(shoot, 1'b0);
    conclude();
  end
endmodule : testbench
`default_nettype wire
